/* File: rtl/bors_pkg.sv */
// Package for the brown-out reset sequencer: register map, fields, timing constants.
// Assumes a 100 MHz system clock and an APB slave with 32-bit data.
package bors_pkg;
    // Register byte offsets
    localparam logic [7:0] ADDR_RST_CTRL = 8'h00;
    localparam logic [7:0] ADDR_OSC_CTRL = 8'h04;
    localparam logic [7:0] ADDR_CFG = 8'h08;
    localparam logic [7:0] ADDR_IRQ_STAT = 8'h0C;
    localparam logic [7:0] ADDR_IRQ_MASK = 8'h10;
    localparam logic [7:0] ADDR_POWER_UP_TIMER_CFG = 8'h14;
    // Field positions
    localparam int BIT_BOR_FLAG = 1;
    localparam int BIT_PLL_LOCK = 5;
    localparam int BIT_IRQ_BOR = 0;
    localparam int BIT_IRQ_RELEASE = 1;
    localparam int CFG_OSC_LSB = 0;
    localparam int CFG_POSC_LSB = 4;
    localparam int CFG_PLL_EN = 8;
    // Oscillator selection codes
    localparam logic [2:0] OSC_SEL_FRC = 3'h0;
    localparam logic [2:0] OSC_SEL_FRC_PLL = 3'h1;
    localparam logic [2:0] OSC_SEL_PRI = 3'h2;
    localparam logic [2:0] OSC_SEL_PRI_PLL = 3'h3;
    // Primary oscillator modes
    localparam logic [1:0] POSC_EC = 2'h0;
    localparam logic [1:0] POSC_XT = 2'h1;
    localparam logic [1:0] POSC_HS = 2'h2;
    localparam logic [1:0] POSC_OFF = 2'h3;
    // Reset values
    localparam logic [8:0] CFG_RESET = 9'h000;
    localparam logic [1:0] MASK_RESET = 2'h0;
    localparam logic POWER_UP_TIMER_EN_RESET = 1'b1;
    // Timing in microseconds and derived cycle counts at 100 MHz
    localparam int CLK_MHZ = 100;
    localparam int RESET_PULSE_CYCLES = 4;
    localparam int OST_CYCLES_DEFAULT = 1024;
    localparam int POWER_UP_TIMER_US = 64;
    localparam int POWER_UP_TIMER_CYCLES = POWER_UP_TIMER_US * CLK_MHZ;
    localparam int FSCM_US = 500;
    localparam int FSCM_CYCLES = FSCM_US * CLK_MHZ;
    localparam int CNT_W = 20;
    typedef enum logic [2:0] {
        BORS_RUN,
        BORS_PULSE,
        BORS_WAIT,
        BORS_HOLD
    } bors_state_t;
endpackage

/* File: rtl/bors_timer.sv */
// Down-counting delay timer used for the start-up and power-up delays.
// Assumes the load value is held stable while start is pulsed.
`timescale 1ns/10ps
`default_nettype none
module bors_timer (
    input wire logic clk_sys_i, // System clock
    input wire logic resetn_i, // Async reset, active low
    input wire logic start_i, // Load pulse
    input wire logic [bors_pkg::CNT_W-1:0] load_i, // Cycles to count
    output logic done_o // High once the count has run out
);
    logic [bors_pkg::CNT_W-1:0] cnt_q;
    logic [bors_pkg::CNT_W-1:0] cnt_d;
    logic done_q;
    logic done_d;

    always_comb
    begin
        cnt_d = cnt_q;
        done_d = done_q;
        if (start_i)
        begin
            cnt_d = load_i;
            done_d = (load_i == '0);
        end
        else if (cnt_q > {{(bors_pkg::CNT_W-1){1'b0}}, 1'b1})
        begin
            cnt_d = cnt_q - {{(bors_pkg::CNT_W-1){1'b0}}, 1'b1};
        end
        else
        begin
            cnt_d = '0;
            done_d = 1'b1;
        end
    end

    always_ff @(posedge clk_sys_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            cnt_q <= '0;
            done_q <= 1'b1;
        end
        else
        begin
            cnt_q <= cnt_d;
            done_q <= done_d;
        end
    end

    assign done_o = done_q;
endmodule
`default_nettype wire

/* File: rtl/bors_top.sv */
// Brown-out reset sequencer: reset pulse, clock source choice, clock hold and
// power-up delay after a brown-out, with sticky status and APB registers.
// Assumes the supply monitor input is already synchronous to clk_sys_i and the
// sequencer itself sits in an always-on domain not reset by its own output.
//
// The APB slave port and the register offsets were left to the implementer.
`timescale 1ns/10ps
`default_nettype none
module bors_top #(
    parameter int OST_CYCLES = bors_pkg::OST_CYCLES_DEFAULT, // Start-up timer length
    parameter int POWER_UP_TIMER_CYC = bors_pkg::POWER_UP_TIMER_CYCLES, // Power-up timeout length
    parameter int FSCM_CYC = bors_pkg::FSCM_CYCLES // Fail-safe start delay length
) (
    input wire logic clk_sys_i, // System clock, 100 MHz
    input wire logic resetn_i, // Async reset, active low
    input wire logic brownout_i, // Supply monitor brown-out level
    input wire logic pll_lock_i, // PLL lock from the clock generator
    input wire logic low_power_i, // Sleep or Idle in effect
    input wire logic psel_i, // APB select
    input wire logic penable_i, // APB enable
    input wire logic pwrite_i, // APB direction
    input wire logic [7:0] paddr_i, // APB byte address
    input wire logic [31:0] pwdata_i, // APB write data
    output logic [31:0] prdata_o, // APB read data
    output logic pready_o, // APB ready
    output logic pslverr_o, // APB error on unmapped address
    output logic device_reset_o, // Reset pulse to the device
    output logic int_reset_o, // Internal reset, held until delay done
    output logic clk_gate_o, // System clock enable
    output logic [2:0] clk_src_o, // Selected clock source
    output logic [1:0] posc_mode_o, // Selected primary oscillator mode
    output logic irq_o // Interrupt, level
);
    bors_pkg::bors_state_t st_q, st_d;
    logic [2:0] pulse_q, pulse_d;
    logic bor_flag_q, bor_flag_d;
    logic [8:0] cfg_q, cfg_d;
    logic power_up_timer_en_q, power_up_timer_en_d;
    logic [1:0] stat_q, stat_d;
    logic [1:0] mask_q, mask_d;
    logic [2:0] src_q, src_d;
    logic [1:0] mode_q, mode_d;
    logic dev_rst_q, dev_rst_d;
    logic int_rst_q, int_rst_d;
    logic gate_q, gate_d;
    logic ost_start, pwr_start;
    logic [bors_pkg::CNT_W-1:0] ost_load, pwr_load;
    logic ost_done, pwr_done;
    logic [31:0] rdata_q, rdata_d;
    logic ready_q, ready_d;
    logic err_q, err_d;
    logic irq_q, irq_d;
    logic bor_prev_q;
    logic bor_rise;
    logic wr_en;
    logic rd_en;

    function automatic logic is_osc(input logic [2:0] sel, input logic [1:0] mode);
        is_osc = (sel == bors_pkg::OSC_SEL_PRI || sel == bors_pkg::OSC_SEL_PRI_PLL)
            && mode != bors_pkg::POSC_OFF;
    endfunction

    function automatic logic is_pll(input logic [2:0] sel);
        is_pll = (sel == bors_pkg::OSC_SEL_FRC_PLL || sel == bors_pkg::OSC_SEL_PRI_PLL);
    endfunction

    function automatic logic is_xtal(input logic [2:0] sel, input logic [1:0] mode);
        is_xtal = is_osc(sel, mode) && (mode == bors_pkg::POSC_XT || mode == bors_pkg::POSC_HS);
    endfunction

    function automatic logic is_mapped(input logic [7:0] a);
        is_mapped = a == bors_pkg::ADDR_RST_CTRL || a == bors_pkg::ADDR_OSC_CTRL
            || a == bors_pkg::ADDR_CFG || a == bors_pkg::ADDR_IRQ_STAT
            || a == bors_pkg::ADDR_IRQ_MASK || a == bors_pkg::ADDR_POWER_UP_TIMER_CFG;
    endfunction

    // Monitor is sampled regardless of low-power state
    assign bor_rise = brownout_i && !bor_prev_q;
    // Write lands at the access edge, the one at which pready is high
    assign wr_en = psel_i && penable_i && pwrite_i && ready_q && is_mapped(paddr_i);
    assign rd_en = psel_i && !penable_i && !pwrite_i;

    // Start-up timer loads at the end of the reset pulse
    assign ost_start = (st_q == bors_pkg::BORS_PULSE) && (pulse_q == 3'h0)
        && is_osc(src_q, mode_q);
    assign ost_load = OST_CYCLES[bors_pkg::CNT_W-1:0];
    assign pwr_start = (st_q == bors_pkg::BORS_PULSE) && (pulse_q == 3'h0);
    // Zero power-up timeout with crystal swaps in the fail-safe delay
    always_comb
    begin
        if (power_up_timer_en_q)
            pwr_load = POWER_UP_TIMER_CYC[bors_pkg::CNT_W-1:0];
        else if (is_xtal(src_q, mode_q))
            pwr_load = FSCM_CYC[bors_pkg::CNT_W-1:0];
        else
            pwr_load = '0;
    end

    bors_timer u_ost (
        .clk_sys_i(clk_sys_i),
        .resetn_i(resetn_i),
        .start_i(ost_start),
        .load_i(ost_load),
        .done_o(ost_done)
    );

    bors_timer u_pwr (
        .clk_sys_i(clk_sys_i),
        .resetn_i(resetn_i),
        .start_i(pwr_start),
        .load_i(pwr_load),
        .done_o(pwr_done)
    );

    // Sequencer
    always_comb
    begin
        st_d = st_q;
        pulse_d = pulse_q;
        src_d = src_q;
        mode_d = mode_q;
        dev_rst_d = 1'b0;
        int_rst_d = int_rst_q;
        gate_d = gate_q;
        // A new brown-out restarts the sequence from any state
        if (bor_rise)
        begin
            st_d = bors_pkg::BORS_PULSE;
            pulse_d = bors_pkg::RESET_PULSE_CYCLES[2:0] - 3'h1;
            src_d = cfg_q[bors_pkg::CFG_OSC_LSB +: 3];
            mode_d = cfg_q[bors_pkg::CFG_POSC_LSB +: 2];
            dev_rst_d = 1'b1;
            int_rst_d = 1'b1;
            gate_d = 1'b0;
        end
        else
        begin
            unique case (st_q)
                bors_pkg::BORS_RUN:
                begin
                    int_rst_d = 1'b0;
                end
                bors_pkg::BORS_PULSE:
                begin
                    dev_rst_d = (pulse_q != 3'h0);
                    if (pulse_q == 3'h0)
                        st_d = bors_pkg::BORS_WAIT;
                    else
                        pulse_d = pulse_q - 3'h1;
                end
                bors_pkg::BORS_WAIT:
                begin
                    // Clock stays gated until oscillator ready and PLL locked
                    if (ost_done && (!is_pll(src_q) || pll_lock_i))
                    begin
                        gate_d = 1'b1;
                        st_d = bors_pkg::BORS_HOLD;
                    end
                end
                bors_pkg::BORS_HOLD:
                begin
                    // Gate the clock again and go back to waiting if lock drops before release
                    if (is_pll(src_q) && !pll_lock_i)
                    begin
                        gate_d = 1'b0;
                        st_d = bors_pkg::BORS_WAIT;
                    end
                    else if (pwr_done)
                    begin
                        int_rst_d = 1'b0;
                        st_d = bors_pkg::BORS_RUN;
                    end
                end
            endcase
        end
    end

    // Registers and sticky flags
    always_comb
    begin
        cfg_d = cfg_q;
        power_up_timer_en_d = power_up_timer_en_q;
        mask_d = mask_q;
        bor_flag_d = bor_flag_q;
        stat_d = stat_q;
        if (wr_en && paddr_i == bors_pkg::ADDR_RST_CTRL && !pwdata_i[bors_pkg::BIT_BOR_FLAG])
            bor_flag_d = 1'b0;
        if (wr_en && paddr_i == bors_pkg::ADDR_CFG)
            cfg_d = pwdata_i[8:0];
        if (wr_en && paddr_i == bors_pkg::ADDR_POWER_UP_TIMER_CFG)
            power_up_timer_en_d = pwdata_i[0];
        if (wr_en && paddr_i == bors_pkg::ADDR_IRQ_MASK)
            mask_d = pwdata_i[1:0];
        if (wr_en && paddr_i == bors_pkg::ADDR_IRQ_STAT)
            stat_d = stat_q & ~pwdata_i[1:0];
        // Set wins over a same-cycle clear
        if (bor_rise)
        begin
            bor_flag_d = 1'b1;
            stat_d[bors_pkg::BIT_IRQ_BOR] = 1'b1;
        end
        if (st_q == bors_pkg::BORS_HOLD && st_d == bors_pkg::BORS_RUN)
            stat_d[bors_pkg::BIT_IRQ_RELEASE] = 1'b1;
        irq_d = |(stat_d & mask_d);
    end

    // APB answers with zero wait states: ready in the access cycle
    always_comb
    begin
        rdata_d = '0;
        ready_d = psel_i && !penable_i;
        err_d = psel_i && !penable_i && !is_mapped(paddr_i);
        if (rd_en)
        begin
            unique case (paddr_i)
                bors_pkg::ADDR_RST_CTRL:
                    rdata_d[bors_pkg::BIT_BOR_FLAG] = bor_flag_q;
                bors_pkg::ADDR_OSC_CTRL:
                begin
                    rdata_d[bors_pkg::BIT_PLL_LOCK] = pll_lock_i;
                    rdata_d[2:0] = src_q;
                end
                bors_pkg::ADDR_CFG:
                    rdata_d[8:0] = cfg_q;
                bors_pkg::ADDR_IRQ_STAT:
                    rdata_d[1:0] = stat_q;
                bors_pkg::ADDR_IRQ_MASK:
                    rdata_d[1:0] = mask_q;
                bors_pkg::ADDR_POWER_UP_TIMER_CFG:
                    rdata_d[0] = power_up_timer_en_q;
                default:
                    rdata_d = '0;
            endcase
        end
    end

    // Flag is in the always-on domain so it survives the device reset
    always_ff @(posedge clk_sys_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            st_q <= bors_pkg::BORS_RUN;
            pulse_q <= 3'h0;
            src_q <= 3'h0;
            mode_q <= 2'h0;
            dev_rst_q <= 1'b0;
            int_rst_q <= 1'b0;
            gate_q <= 1'b1;
            bor_prev_q <= 1'b0;
            bor_flag_q <= 1'b0;
            cfg_q <= bors_pkg::CFG_RESET;
            power_up_timer_en_q <= bors_pkg::POWER_UP_TIMER_EN_RESET;
            stat_q <= 2'h0;
            mask_q <= bors_pkg::MASK_RESET;
            irq_q <= 1'b0;
            rdata_q <= 32'h0000_0000;
            ready_q <= 1'b0;
            err_q <= 1'b0;
        end
        else
        begin
            st_q <= st_d;
            pulse_q <= pulse_d;
            src_q <= src_d;
            mode_q <= mode_d;
            dev_rst_q <= dev_rst_d;
            int_rst_q <= int_rst_d;
            gate_q <= gate_d;
            bor_prev_q <= brownout_i;
            bor_flag_q <= bor_flag_d;
            cfg_q <= cfg_d;
            power_up_timer_en_q <= power_up_timer_en_d;
            stat_q <= stat_d;
            mask_q <= mask_d;
            irq_q <= irq_d;
            rdata_q <= rdata_d;
            ready_q <= ready_d;
            err_q <= err_d;
        end
    end

    assign prdata_o = rdata_q;
    assign pready_o = ready_q;
    assign pslverr_o = err_q;
    assign device_reset_o = dev_rst_q;
    assign int_reset_o = int_rst_q;
    assign clk_gate_o = gate_q;
    assign clk_src_o = src_q;
    assign posc_mode_o = mode_q;
    assign irq_o = irq_q;
endmodule
`default_nettype wire

/* File: tb/bors_checker.sv */
// Concurrent checks on the ports of the brown-out reset sequencer top.
// Assumes one clock domain; bound to every bors_top instance.
`timescale 1ns/10ps
`default_nettype none
module bors_checker #(
    parameter int OST_CYCLES = 8, // Start-up timer length
    parameter int POWER_UP_TIMER_CYC = 16, // Power-up timeout length
    parameter int FSCM_CYC = 32 // Fail-safe delay length
) (
    input wire logic clk_sys_i, // Clock
    input wire logic resetn_i, // Reset, active low
    input wire logic brownout_i, // Brown-out level
    input wire logic pll_lock_i, // PLL lock
    input wire logic low_power_i, // Sleep or Idle
    input wire logic psel_i, // APB select
    input wire logic penable_i, // APB enable
    input wire logic pwrite_i, // APB direction
    input wire logic [7:0] paddr_i, // APB address
    input wire logic [31:0] pwdata_i, // APB write data
    input wire logic [31:0] prdata_o, // APB read data
    input wire logic pready_o, // APB ready
    input wire logic pslverr_o, // APB error
    input wire logic device_reset_o, // Reset pulse
    input wire logic int_reset_o, // Internal reset
    input wire logic clk_gate_o, // Clock enable
    input wire logic [2:0] clk_src_o, // Clock source
    input wire logic [1:0] posc_mode_o, // Primary mode
    input wire logic irq_o // Interrupt
);
    // One cycle of slack: the timers load in the last cycle of the pulse
    localparam int OST_MIN = OST_CYCLES - 1;
    logic [7:0] gap_q;
    logic [7:0] gap_d;
    always_comb
    begin
        gap_d = gap_q;
        if (device_reset_o)
            gap_d = 8'h00;
        else if (gap_q != 8'hFF)
            gap_d = gap_q + 8'h01;
    end
    always_ff @(posedge clk_sys_i or negedge resetn_i)
    begin
        if (!resetn_i)
            gap_q <= 8'h00;
        else
            gap_q <= gap_d;
    end
    default clocking cb @(posedge clk_sys_i);
    endclocking
    default disable iff (!resetn_i);
    sequence s_held;
        device_reset_o && int_reset_o && !clk_gate_o;
    endsequence
    sequence s_pulse;
        device_reset_o [*4] ##1 !device_reset_o;
    endsequence
    a_pulse_start: assert property ($rose(brownout_i) |=> s_held) else $error("no reset on brown-out");
    a_pulse_len: assert property ($rose(device_reset_o) |-> s_pulse) else $error("pulse length wrong");
    a_sleep_reset: assert property (low_power_i && $rose(brownout_i) |=> $rose(device_reset_o))
        else $error("no reset in low power");
    a_src_latch: assert property ($changed(clk_src_o) |-> $rose(device_reset_o)) else $error("source moved");
    a_ost_hold: assert property ($rose(clk_gate_o) && clk_src_o[1] && posc_mode_o != 2'h3 |-> int'(gap_q) >= OST_MIN)
        else $error("clock released before start-up timer");
    a_lock_gate: assert property ($rose(clk_gate_o) && clk_src_o[0] |-> $past(pll_lock_i))
        else $error("clock released without lock");
    a_lock_regate: assert property (int_reset_o && clk_src_o[0] && !pll_lock_i |=> !clk_gate_o)
        else $error("clock running without lock");
    a_release_order: assert property ($fell(int_reset_o) |-> clk_gate_o && $past(clk_gate_o))
        else $error("reset released before clock");
    a_ready_setup: assert property (psel_i && !penable_i |=> pready_o) else $error("no ready");
    a_err_ready: assert property (pslverr_o |-> pready_o) else $error("error without ready");
endmodule
bind bors_top bors_checker #(.OST_CYCLES(OST_CYCLES), .POWER_UP_TIMER_CYC(POWER_UP_TIMER_CYC), .FSCM_CYC(FSCM_CYC)) u_bors_checker (
    .clk_sys_i, .resetn_i, .brownout_i, .pll_lock_i, .low_power_i, .psel_i, .penable_i, .pwrite_i, .paddr_i,
    .pwdata_i, .prdata_o, .pready_o, .pslverr_o, .device_reset_o, .int_reset_o, .clk_gate_o, .clk_src_o,
    .posc_mode_o, .irq_o);
`default_nettype wire

/* File: tb/tb_bors_top.sv */
// Self-checking bench for the brown-out reset sequencer top.
// Assumes shortened delay counts; APB master samples ready at the rising edge.
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, e, s) begin n_checks++; if ((s) !== (e)) begin err_total++; $display("BAD %s exp %0h got %0h", nm, e, s); end end
module tb_bors_top;
    localparam int OSC_STARTUP_TIMER = 8;
    localparam int PW = 16;
    localparam int FS = 32;
    localparam int LK = 20;
    logic clk_sys_i, resetn_i, brownout_i, pll_lock_i, low_power_i, psel_i, penable_i, pwrite_i;
    logic [7:0] paddr_i;
    logic [31:0] pwdata_i, prdata_o, rd;
    logic pready_o, pslverr_o, device_reset_o, int_reset_o, clk_gate_o, irq_o, er;
    logic [2:0] clk_src_o;
    logic [1:0] posc_mode_o;
    logic [15:0] rnd;
    int err_total, n_checks;
    bors_top #(.OST_CYCLES(OSC_STARTUP_TIMER), .POWER_UP_TIMER_CYC(PW), .FSCM_CYC(FS)) u_bors_top (
        .clk_sys_i, .resetn_i, .brownout_i, .pll_lock_i, .low_power_i, .psel_i, .penable_i, .pwrite_i, .paddr_i,
        .pwdata_i, .prdata_o, .pready_o, .pslverr_o, .device_reset_o, .int_reset_o, .clk_gate_o, .clk_src_o,
        .posc_mode_o, .irq_o);
    initial
    begin
        clk_sys_i = 1'b0;
        forever #5 clk_sys_i = ~clk_sys_i;
    end
    function automatic logic [15:0] lfsr(input logic [15:0] v);
        return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
    endfunction
    // Timers run in parallel, so the longest one sets the release
    function automatic int exp_lo(input logic [2:0] s, input logic [1:0] m, input logic p);
        int t;
        logic osc;
        osc = s[1] && m != 2'h3;
        t = p ? PW : ((osc && m != 2'h0) ? FS : 0);
        if (osc && t < OSC_STARTUP_TIMER)
            t = OSC_STARTUP_TIMER;
        if (s[0] && t < LK)
            t = LK;
        return t;
    endfunction
    task automatic end_of_test();
        $display("checks %0d errors %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_sys_i);
        psel_i <= 1'b1;
        penable_i <= 1'b0;
        pwrite_i <= w;
        paddr_i <= a;
        pwdata_i <= d;
        @(posedge clk_sys_i);
        penable_i <= 1'b1;
        @(posedge clk_sys_i);
        while (pready_o !== 1'b1)
        begin
            n++;
            if (n > 20)
            begin
                err_total++;
                end_of_test();
            end
            @(posedge clk_sys_i);
        end
        rd = prdata_o;
        er = pslverr_o;
        psel_i <= 1'b0;
        penable_i <= 1'b0;
    endtask
    task automatic rchk(input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        `CHK("register", e, rd)
    endtask
    task automatic irqchk(input logic e);
        @(posedge clk_sys_i);
        @(negedge clk_sys_i);
        `CHK("irq", e, irq_o)
    endtask
    task automatic seq(input logic [2:0] s, input logic [1:0] m, input logic p, input logic lp);
        int t;
        int lo;
        t = 0;
        lo = exp_lo(s, m, p);
        apb(1'b1, bors_pkg::ADDR_CFG, {26'h0, m, 1'b0, s});
        apb(1'b1, bors_pkg::ADDR_POWER_UP_TIMER_CFG, {31'h0, p});
        @(posedge clk_sys_i);
        brownout_i <= 1'b1;
        low_power_i <= lp;
        pll_lock_i <= ~s[0];
        @(posedge clk_sys_i);
        @(negedge clk_sys_i);
        `CHK("held", 3'h6, {device_reset_o, int_reset_o, clk_gate_o})
        `CHK("source", {m, s}, {posc_mode_o, clk_src_o})
        while (device_reset_o === 1'b1 && t < 9)
        begin
            t++;
            @(negedge clk_sys_i);
        end
        `CHK("pulse", 4, t)
        t = 0;
        while (int_reset_o !== 1'b0 && t < 200)
        begin
            @(posedge clk_sys_i);
            if (t == LK)
                pll_lock_i <= 1'b1;
            @(negedge clk_sys_i);
            if (s[0] && t < LK)
                `CHK("gate", 1'b0, clk_gate_o)
            t++;
        end
        `CHK("release", 1'b1, t >= lo && t <= lo + 8)
        @(posedge clk_sys_i);
        brownout_i <= 1'b0;
        rchk(bors_pkg::ADDR_RST_CTRL, 32'h2);
        apb(1'b1, bors_pkg::ADDR_RST_CTRL, 32'h2);
        rchk(bors_pkg::ADDR_RST_CTRL, 32'h2);
        apb(1'b1, bors_pkg::ADDR_RST_CTRL, 32'h0);
        rchk(bors_pkg::ADDR_RST_CTRL, 32'h0);
        rchk(bors_pkg::ADDR_OSC_CTRL, {26'h0, 1'b1, 2'h0, s});
        rchk(bors_pkg::ADDR_IRQ_STAT, 32'h3);
        irqchk(1'b0);
        apb(1'b1, bors_pkg::ADDR_IRQ_MASK, 32'h3);
        irqchk(1'b1);
        apb(1'b1, bors_pkg::ADDR_IRQ_STAT, 32'h3);
        irqchk(1'b0);
        apb(1'b1, bors_pkg::ADDR_IRQ_MASK, 32'h0);
        rchk(bors_pkg::ADDR_IRQ_STAT, 32'h0);
    endtask
    initial
    begin
        repeat (100000) @(posedge clk_sys_i);
        err_total++;
        end_of_test();
    end
    initial
    begin
        resetn_i = 1'b0;
        brownout_i = 1'b0;
        pll_lock_i = 1'b0;
        low_power_i = 1'b0;
        psel_i = 1'b0;
        penable_i = 1'b0;
        pwrite_i = 1'b0;
        paddr_i = 8'h00;
        pwdata_i = 32'h0;
        err_total = 0;
        n_checks = 0;
        rnd = 16'h818C;
        repeat (2) @(posedge clk_sys_i);
        resetn_i <= 1'b1;
        rchk(bors_pkg::ADDR_RST_CTRL, 32'h0);
        rchk(bors_pkg::ADDR_OSC_CTRL, 32'h0);
        rchk(bors_pkg::ADDR_CFG, 32'h0);
        rchk(bors_pkg::ADDR_IRQ_STAT, 32'h0);
        rchk(bors_pkg::ADDR_IRQ_MASK, 32'h0);
        rchk(bors_pkg::ADDR_POWER_UP_TIMER_CFG, 32'h1);
        apb(1'b1, 8'h18, 32'hFFFFFFFF);
        rchk(8'h18, 32'h0);
        `CHK("slverr", 1'b1, er)
        apb(1'b1, bors_pkg::ADDR_CFG, 32'hFFFFFFFF);
        rchk(bors_pkg::ADDR_CFG, 32'h1FF);
        for (int i = 0; i < 12; i++)
        begin
            rnd = lfsr(rnd);
            // Crystal with the power-up timer off, with and without PLL
            if (i == 6 || i == 7)
                seq(3'(i % 4), 2'(i - 5), 1'b0, rnd[3]);
            else
                seq(3'(i % 4), rnd[1:0], rnd[2], rnd[3]);
        end
        end_of_test();
    end
endmodule
`default_nettype wire
